//--- design/laf_commutation.sv
// Load-adaptive fullstep commutation for one stepper axis, AHB-Lite slave.
// Assumes a ramp generator supplying velocity and direction, and a power
// stage reporting coil settle; all inputs synchronous to clk_sys.
// Overview of operation
// - Fullstep at ramp velocity, slower under load
// - Zero minimum velocity disables the mode
// - Below minimum velocity use ordinary microsteps
// - Never step slower than minimum velocity
// - Quiet chopper off while fullstepping
// - Both high-speed flags needed for fullstep
// - Off-time settings above eight act as eight while fullstepping
// - Pulse width is the load reference
// - Higher stall setting means more sensitive
// - Stop-on-stall forces ramp velocity to zero
// - Status read releases the stall stop
// - Stall-stop event flag shows active stop
// - Load value reported, clamped at 511
// - Wave polarity fixed by counter quadrant
// - Velocity register shows unmodified ramp velocity
// - Without stop, motor resumes when load released
// - Blocked motor sets the stall flag
// - No stall detection below load minimum velocity; load value still measured
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/1ps
`include "laf_params.svh"
module laf_commutation (
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  // Register bus
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Motion side
  input  wire logic [laf_pkg::VEL_W-1:0] ramp_velocity,
  input  wire logic                      ramp_dir,
  output logic                           ramp_stop_request,
  output logic                           step_taken,
  output logic                           step_dir,
  input  wire logic                      coil_settled,
  output logic [9:0]                     microstep_counter,
  output logic                           coil_a_positive,
  output logic                           coil_b_positive,
  output logic                           fullstep_active,
  output logic                           quiet_chopper_disable,
  output logic [3:0]                     chopper_off_time_eff,
  output logic                           load_measure_active
);

  localparam int VW = laf_pkg::VEL_W;

  typedef struct packed {
    laf_pkg::cfg_s cfg;

    logic          wr_pending;
    logic [7:0]    wr_addr;
    logic [31:0]   rdata;

    logic [9:0]    ms_cnt;
    logic [31:0]   pos;

    logic [8:0]    credit;
    logic          stop_latched;
    logic          stall_flag;

    logic          step_taken;
    logic          step_dir;
  } axis_state_s;

  axis_state_s st_reg;
  axis_state_s st_next;

  logic        addr_ok;
  logic        stat_read;

  logic        mode_enabled;
  logic        run;

  logic        ramp_carry;
  logic        min_carry;
  logic        ramp_due;
  logic        fs_step;
  logic        us_step;

  logic        follow_ok;
  logic [8:0]  load_value;
  logic        stall_pulse;
  logic        stall_event;
  logic [12:0] lim_wide;
  logic [10:0] stall_limit;

  logic [9:0]  fs_pos;
  logic [31:0] step_delta;

  function automatic logic [5:0] blank_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    blank_cycles = `LAF_BLANK_0;
      2'h1:    blank_cycles = `LAF_BLANK_1;
      2'h2:    blank_cycles = `LAF_BLANK_2;
      default: blank_cycles = `LAF_BLANK_3;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input axis_state_s s,
                                           input logic [7:0] a,
                                           input logic [VW-1:0] vel,
                                           input logic full);
    read_mux = 32'h0000_0000;
    case (a)
      `LAF_OFS_MODE_MIN:  read_mux[VW-1:0] = s.cfg.mode_min_velocity;
      `LAF_OFS_LOAD_MIN:
        read_mux[VW-1:0] = s.cfg.load_measure_min_velocity;
      `LAF_OFS_MAX_VEL:   read_mux[VW-1:0] = s.cfg.max_velocity;
      `LAF_OFS_CHOP_CFG: begin
        read_mux[`LAF_CHOP_OFF_LSB +: 4]  = s.cfg.chopper_off_time;
        read_mux[`LAF_CHOP_TBL_LSB +: 2]  = s.cfg.blank_time_select;
        read_mux[`LAF_CHOP_VHIGHFS_BIT]   = s.cfg.vhigh_fullstep;
        read_mux[`LAF_CHOP_VHIGHCHM_BIT]  = s.cfg.vhigh_chopper;
      end
      `LAF_OFS_LOAD_CFG: begin
        read_mux[`LAF_LOAD_PW_LSB +: 10]  = s.cfg.load_pulse_width;
        read_mux[`LAF_LOAD_SENS_LSB +: 8] = s.cfg.stall_sensitivity;
      end
      `LAF_OFS_RAMP_CTRL: read_mux[0] = s.cfg.stop_on_stall_enable;
      `LAF_OFS_RAMP_STAT: begin
        read_mux[`LAF_STAT_STOP_BIT]  = s.stop_latched;
        read_mux[`LAF_STAT_STALL_BIT] = s.stall_flag;
        read_mux[`LAF_STAT_FULL_BIT]  = full;
      end
      `LAF_OFS_RAMP_VEL:  read_mux[VW-1:0] = vel;
      `LAF_OFS_MS_CNT:    read_mux[9:0] = s.ms_cnt;
      `LAF_OFS_POS:       read_mux = s.pos;
      default:            read_mux = 32'h0000_0000;
    endcase
  endfunction

  // Mode selection is combinational so it switches on the compare cycle
  assign mode_enabled = (st_reg.cfg.mode_min_velocity != '0);
  assign fullstep_active = mode_enabled && st_reg.cfg.vhigh_fullstep
                        && st_reg.cfg.vhigh_chopper
                        && (ramp_velocity > st_reg.cfg.mode_min_velocity);

  assign quiet_chopper_disable = fullstep_active;
  assign chopper_off_time_eff =
    (fullstep_active && st_reg.cfg.chopper_off_time > `LAF_OFF_TIME_CAP)
    ? `LAF_OFF_TIME_CAP : st_reg.cfg.chopper_off_time;

  assign load_measure_active =
    (ramp_velocity >= st_reg.cfg.load_measure_min_velocity);

  assign run      = !st_reg.stop_latched;
  assign ramp_due = (st_reg.credit >= `LAF_FS_SPAN);

  assign fs_step  = fullstep_active && run
                 && ((ramp_due && follow_ok) || min_carry);
  assign us_step  = !fullstep_active && run && ramp_carry;

  // Higher sensitivity lowers the settle-time limit for a stall
  assign lim_wide = {2'b00, st_reg.cfg.load_pulse_width, 1'b0}
                  - {1'b0, st_reg.cfg.stall_sensitivity, 4'h0};

  assign stall_limit = (lim_wide[12] || lim_wide == 13'h0000)
                     ? 11'h001 : lim_wide[10:0];

  assign stall_event = stall_pulse && fullstep_active
                    && load_measure_active;

  // Fullsteps land mid-quadrant so both polarities are unambiguous
  assign fs_pos = ramp_dir ? {st_reg.ms_cnt[9:8] - 2'h1, `LAF_FS_OFFSET}
                           : {st_reg.ms_cnt[9:8] + 2'h1, `LAF_FS_OFFSET};

  assign step_delta = fs_step ? {23'h00_0000, `LAF_FS_SPAN}
                              : 32'h0000_0001;

  rate_accumulator #(
    .VW (VW),
    .AW (24)
  ) u_ramp_acc (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .enable  (run),
    .clear   (1'b0),
    .rate    (ramp_velocity),
    .carry   (ramp_carry)
  );

  // Forced fullstep at minimum velocity
  rate_accumulator #(
    .VW (VW),
    .AW (32)
  ) u_min_acc (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .enable  (fullstep_active && run),
    .clear   (!fullstep_active || fs_step),
    .rate    (st_reg.cfg.mode_min_velocity),
    .carry   (min_carry)
  );

  // Settle time after each fullstep
  load_meter u_meter (
    .clk_sys      (clk_sys),
    .rstn         (rstn),
    .enable       (fullstep_active),
    .start        (fs_step),
    .coil_settled (coil_settled),
    .blank_cycles (blank_cycles(st_reg.cfg.blank_time_select)),
    .pulse_width  (st_reg.cfg.load_pulse_width),
    .stall_limit  (stall_limit),
    .follow_ok    (follow_ok),
    .load_value   (load_value),
    .stall_pulse  (stall_pulse)
  );

  // Zero wait states
  assign addr_ok   = hsel && htrans[1] && hready;

  assign stat_read = addr_ok && !hwrite
                  && (haddr[7:0] == `LAF_OFS_RAMP_STAT);

  always_comb begin
    st_next            = st_reg;
    st_next.step_taken = fs_step || us_step;
    st_next.step_dir   = ramp_dir;
    st_next.wr_pending = addr_ok && hwrite;

    // Address phase
    if (addr_ok) begin
      st_next.wr_addr = haddr[7:0];
      if (!hwrite) begin
        if (haddr[7:0] == `LAF_OFS_LOAD_VAL) begin
          st_next.rdata = {23'h00_0000, load_value};
        end else begin
          st_next.rdata = read_mux(st_reg, haddr[7:0], ramp_velocity,
                                   fullstep_active);
        end
      end
    end

    // Data phase write
    if (st_reg.wr_pending) begin
      case (st_reg.wr_addr)
        `LAF_OFS_MODE_MIN:
          st_next.cfg.mode_min_velocity = hwdata[VW-1:0];
        `LAF_OFS_LOAD_MIN:
          st_next.cfg.load_measure_min_velocity = hwdata[VW-1:0];
        `LAF_OFS_MAX_VEL:
          st_next.cfg.max_velocity = hwdata[VW-1:0];
        `LAF_OFS_CHOP_CFG: begin
          st_next.cfg.chopper_off_time  = hwdata[`LAF_CHOP_OFF_LSB +: 4];
          st_next.cfg.blank_time_select = hwdata[`LAF_CHOP_TBL_LSB +: 2];
          st_next.cfg.vhigh_fullstep    = hwdata[`LAF_CHOP_VHIGHFS_BIT];
          st_next.cfg.vhigh_chopper     = hwdata[`LAF_CHOP_VHIGHCHM_BIT];
        end
        `LAF_OFS_LOAD_CFG: begin
          st_next.cfg.load_pulse_width  = hwdata[`LAF_LOAD_PW_LSB +: 10];
          st_next.cfg.stall_sensitivity = hwdata[`LAF_LOAD_SENS_LSB +: 8];
        end
        `LAF_OFS_RAMP_CTRL:
          st_next.cfg.stop_on_stall_enable = hwdata[0];
        default: begin
        end
      endcase
    end

    // Credit of microsteps owed; fullsteps spend it 256 at a time once 256 are owed, forced fullsteps below that spend none
    if (!fullstep_active) begin
      st_next.credit = '0;
    end else begin
      if (fs_step && ramp_due) begin
        st_next.credit = st_reg.credit - `LAF_FS_SPAN;
      end
      if (ramp_carry && st_next.credit != `LAF_CREDIT_MAX) begin
        st_next.credit = st_next.credit + 9'h001;
      end
    end

    if (fs_step) begin
      st_next.ms_cnt = fs_pos;
    end else if (us_step) begin
      st_next.ms_cnt = ramp_dir ? st_reg.ms_cnt - 10'h001
                                : st_reg.ms_cnt + 10'h001;
    end

    if (fs_step || us_step) begin
      st_next.pos = ramp_dir ? st_reg.pos - step_delta
                             : st_reg.pos + step_delta;
    end

    // Set wins over the clear from a status read in the same cycle
    if (stat_read) begin
      st_next.stop_latched = 1'b0;
      st_next.stall_flag   = 1'b0;
    end
    if (stall_event) begin
      st_next.stall_flag = 1'b1;
      if (st_reg.cfg.stop_on_stall_enable) begin
        st_next.stop_latched = 1'b1;
      end
      // Without stop enable stepping simply carries on
    end
  end

  // Reset leaves the mode disabled
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg                       <= '0;
      st_reg.cfg.chopper_off_time  <= `LAF_RST_OFF_TIME;
      st_reg.cfg.blank_time_select <= `LAF_RST_TBL;
      st_reg.cfg.load_pulse_width  <= `LAF_RST_PW;
      st_reg.cfg.stall_sensitivity <= `LAF_RST_SENS;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = st_reg.rdata;

  assign ramp_stop_request = st_reg.stop_latched;
  assign step_taken        = st_reg.step_taken;
  assign step_dir          = st_reg.step_dir;

  assign microstep_counter = st_reg.ms_cnt;
  assign coil_a_positive   = (st_reg.ms_cnt[9:8] == 2'h3)
                          || (st_reg.ms_cnt[9:8] == 2'h0);
  assign coil_b_positive   = !st_reg.ms_cnt[9];

endmodule

//--- design/laf_params.svh
// Offsets, field positions, reset values and counts of the fullstep block.
// Included by the design files; definitions only.
`ifndef LAF_PARAMS_SVH
`define LAF_PARAMS_SVH

`define LAF_OFS_MODE_MIN      8'h00
`define LAF_OFS_LOAD_MIN      8'h04
`define LAF_OFS_MAX_VEL       8'h08
`define LAF_OFS_CHOP_CFG      8'h0C
`define LAF_OFS_LOAD_CFG      8'h10
`define LAF_OFS_RAMP_CTRL     8'h14
`define LAF_OFS_RAMP_STAT     8'h18
`define LAF_OFS_LOAD_VAL      8'h1C
`define LAF_OFS_RAMP_VEL      8'h20
`define LAF_OFS_MS_CNT        8'h24
`define LAF_OFS_POS           8'h28

`define LAF_CHOP_OFF_LSB      0
`define LAF_CHOP_TBL_LSB      4
`define LAF_CHOP_VHIGHFS_BIT  18
`define LAF_CHOP_VHIGHCHM_BIT 19
`define LAF_LOAD_PW_LSB       0
`define LAF_LOAD_SENS_LSB     16
`define LAF_STAT_STOP_BIT     0
`define LAF_STAT_STALL_BIT    1
`define LAF_STAT_FULL_BIT     2

`define LAF_RST_OFF_TIME      4'h3
`define LAF_RST_TBL           2'h1
`define LAF_RST_PW            10'h040
`define LAF_RST_SENS          8'h05

`define LAF_OFF_TIME_CAP      4'h8
`define LAF_BLANK_0           6'h10
`define LAF_BLANK_1           6'h18
`define LAF_BLANK_2           6'h24
`define LAF_BLANK_3           6'h36
`define LAF_FS_OFFSET         8'h80
`define LAF_FS_SPAN           9'h100
`define LAF_CREDIT_MAX        9'h1FF
`define LAF_METER_TIMEOUT     11'h7FF
`define LAF_LOAD_MAX          9'h1FF

`endif

//--- design/laf_pkg.sv
// Types shared by the fullstep commutation block.
// No timing or offsets here; those live in laf_params.svh.
package laf_pkg;

  localparam int VEL_W = 23;

  typedef enum logic [2:0] {
    MEAS_IDLE  = 3'b001,
    MEAS_BLANK = 3'b010,
    MEAS_WAIT  = 3'b100
  } meas_state_e;

  typedef struct packed {
    logic [VEL_W-1:0] mode_min_velocity;
    logic [VEL_W-1:0] load_measure_min_velocity;
    logic [VEL_W-1:0] max_velocity;
    logic [3:0]       chopper_off_time;
    logic [1:0]       blank_time_select;
    logic             vhigh_fullstep;
    logic             vhigh_chopper;
    logic [9:0]       load_pulse_width;
    logic [7:0]       stall_sensitivity;
    logic             stop_on_stall_enable;
  } cfg_s;

endpackage

//--- design/load_meter.sv
// Measures coil settle time after each fullstep against the pulse width.
// Assumes coil_settled is synchronous to clk_sys.
`timescale 1ns/1ps
`include "laf_params.svh"
module load_meter (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        enable,
  input  wire logic        start,
  input  wire logic        coil_settled,
  input  wire logic [5:0]  blank_cycles,
  input  wire logic [9:0]  pulse_width,
  input  wire logic [10:0] stall_limit,
  output logic             follow_ok,
  output logic [8:0]       load_value,
  output logic             stall_pulse
);

  typedef struct packed {
    laf_pkg::meas_state_e state;
    logic [10:0]          cnt;
    logic [8:0]           load;
    logic                 follow;
    logic                 stall;
  } meter_state_s;

  meter_state_s st_reg;
  meter_state_s st_next;
  logic [10:0]  margin;

  assign margin      = {1'b0, pulse_width} - st_reg.cnt;
  assign follow_ok   = st_reg.follow;
  assign load_value  = st_reg.load;
  assign stall_pulse = st_reg.stall;

  always_comb begin
    st_next       = st_reg;
    st_next.stall = 1'b0;
    if (!enable) begin
      st_next.state  = laf_pkg::MEAS_IDLE;
      st_next.follow = 1'b1;
    end else if (start) begin
      st_next.state  = laf_pkg::MEAS_BLANK;
      st_next.cnt    = '0;
      st_next.follow = 1'b0;
    end else begin
      case (st_reg.state)
        laf_pkg::MEAS_IDLE: begin
          st_next.cnt = '0;
        end
        laf_pkg::MEAS_BLANK: begin
          // Ringing right after a step would fake an early settle
          st_next.cnt = st_reg.cnt + 11'h001;
          if (st_reg.cnt == {5'h00, blank_cycles} - 11'h001) begin
            st_next.state = laf_pkg::MEAS_WAIT;
          end
        end
        laf_pkg::MEAS_WAIT: begin
          if (coil_settled || st_reg.cnt == `LAF_METER_TIMEOUT) begin
            st_next.state  = laf_pkg::MEAS_IDLE;
            st_next.follow = 1'b1;
            st_next.stall  = (st_reg.cnt >= stall_limit);
            if (st_reg.cnt >= {1'b0, pulse_width}) begin
              st_next.load = '0;
            end else if (margin > {2'b00, `LAF_LOAD_MAX}) begin
              st_next.load = `LAF_LOAD_MAX;
            end else begin
              st_next.load = margin[8:0];
            end
          end else begin
            st_next.cnt = st_reg.cnt + 11'h001;
          end
        end
        default: begin
          st_next.state = laf_pkg::MEAS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg        <= '0;
      st_reg.state  <= laf_pkg::MEAS_IDLE;
      st_reg.follow <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

//--- design/rate_accumulator.sv
// Phase accumulator: one carry pulse per wrap at a programmed rate.
// Rate is added once per clk_sys cycle while enabled.
`timescale 1ns/1ps
module rate_accumulator #(
  parameter int VW = 23,
  parameter int AW = 24
) (
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  input  wire logic          enable,
  input  wire logic          clear,
  input  wire logic [VW-1:0] rate,
  output logic               carry
);

  typedef struct packed {
    logic [AW-1:0] acc;
  } acc_state_s;

  acc_state_s  st_reg;
  acc_state_s  st_next;
  logic [AW:0] sum;

  // Carry does not look at clear, so a step may restart the interval
  assign sum   = {1'b0, st_reg.acc} + {{(AW+1-VW){1'b0}}, rate};
  assign carry = enable && sum[AW];

  always_comb begin
    st_next = st_reg;
    if (clear) begin
      st_next.acc = '0;
    end else if (enable) begin
      st_next.acc = sum[AW-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

//--- tb/coil_model.sv
// Motor coil model: after each fullstep the current settles late.
// Assumes step_taken is registered on clk_sys and fullstep_active is synchronous to it.
`timescale 1ns/1ps
module coil_model (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        step_taken,
  input  wire logic        fullstep_active,
  input  wire logic        blocked,
  input  wire logic [11:0] settle_cycles,
  output logic             coil_settled
);
  logic [11:0] left;

  // A blocked rotor never lets the current settle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      left <= 12'h000;
      coil_settled <= 1'b1;
    end else if (step_taken && fullstep_active) begin
      left <= settle_cycles;
      coil_settled <= 1'b0;
    end else if (left > 12'h001) begin
      left <= left - 12'h001;
    end else if (!blocked) begin
      coil_settled <= 1'b1;
    end
  end
endmodule

//--- tb/laf_commutation_properties.sv
// Port-level checker for laf_commutation.
// Assumes one clock, clk_sys, and rstn as async active-low reset.
`timescale 1ns/1ps
module laf_commutation_properties (
  input wire logic                      clk_sys,
  input wire logic                      rstn,
  input wire logic                      hsel,
  input wire logic [31:0]               haddr,
  input wire logic [1:0]                htrans,
  input wire logic                      hwrite,
  input wire logic [2:0]                hsize,
  input wire logic [31:0]               hwdata,
  input wire logic                      hready,
  input wire logic                      hreadyout,
  input wire logic                      hresp,
  input wire logic [31:0]               hrdata,
  input wire logic [laf_pkg::VEL_W-1:0] ramp_velocity,
  input wire logic                      ramp_dir,
  input wire logic                      ramp_stop_request,
  input wire logic                      step_taken,
  input wire logic                      step_dir,
  input wire logic                      coil_settled,
  input wire logic [9:0]                microstep_counter,
  input wire logic                      coil_a_positive,
  input wire logic                      coil_b_positive,
  input wire logic                      fullstep_active,
  input wire logic                      quiet_chopper_disable,
  input wire logic [3:0]                chopper_off_time_eff,
  input wire logic                      load_measure_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  logic stat_rd;
  assign stat_rd = hsel && htrans[1] && hready && !hwrite &&
                   haddr[7:0] == 8'h18;

  a_quiet_tracks: assert property (
    quiet_chopper_disable == fullstep_active)
    else $error("quiet chopper disable differs from fullstep mode");
  a_offtime_cap: assert property (
    fullstep_active |-> chopper_off_time_eff <= 4'h8)
    else $error("off time above eight in fullstep mode");
  a_micro_single: assert property (
    step_taken && !$past(fullstep_active) |-> microstep_counter ==
      $past(microstep_counter) + (step_dir ? 10'h3FF : 10'h001))
    else $error("microstep did not move the counter by one");
  a_sine_sign: assert property (
    coil_a_positive == (microstep_counter >= 10'h300 ||
                        microstep_counter < 10'h100))
    else $error("sine polarity wrong for counter value");
  a_cosine_sign: assert property (
    coil_b_positive == (microstep_counter < 10'h200))
    else $error("cosine polarity wrong for counter value");
  a_step_single: assert property (
    step_taken |=> !step_taken)
    else $error("step pulse longer than one cycle");
  a_stop_quiet: assert property (
    ramp_stop_request && $past(ramp_stop_request) |-> !step_taken)
    else $error("step issued while stopped");
  a_stop_holds: assert property (
    ramp_stop_request && !stat_rd |=> ramp_stop_request)
    else $error("stop released without status read");
endmodule

bind laf_commutation laf_commutation_properties
  laf_commutation_properties_i (.*);

//--- tb/test_load_adaptive_fullstep_commutation.sv
// Bench for laf_commutation: AHB-Lite master, ramp input, coil model.
// Assumes the slave answers with hreadyout within a few cycles.
`timescale 1ns/1ps
module test_load_adaptive_fullstep_commutation;
  logic                      clk_sys, rstn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]               haddr, hwdata, hrdata, q;
  logic [1:0]                htrans;
  logic [2:0]                hsize;
  logic [laf_pkg::VEL_W-1:0] ramp_velocity;
  logic                      ramp_dir, ramp_stop_request, step_taken;
  logic                      step_dir, coil_settled, blocked;
  logic                      coil_a_positive, coil_b_positive;
  logic                      fullstep_active, quiet_chopper_disable;
  logic                      load_measure_active;
  logic [9:0]                microstep_counter;
  logic [3:0]                chopper_off_time_eff;
  logic [11:0]               settle_cycles;
  int                        checked, mismatches, n, free_n, blk_n;

  laf_commutation laf_commutation_i (.hready(hreadyout), .*);
  coil_model coil_model_i (.*);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic ready_edge;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 16);
    if (k >= 16) begin
      mismatches++;
      close_out();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    ready_edge();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    ready_edge();
    r = hrdata;
    @(negedge clk_sys);
  endtask

  task automatic setv(input logic [22:0] v);
    @(posedge clk_sys);
    ramp_velocity <= v;
    @(negedge clk_sys);
  endtask

  task automatic count_steps(input int cycles, output int c);
    c = 0;
    repeat (cycles) begin
      @(negedge clk_sys);
      if (step_taken === 1'b1)
        c++;
    end
  endtask

  task automatic t_reset;
    chk("off time eff", 32'(chopper_off_time_eff), 32'h0000_0003);
    chk("okay response", 32'(hresp), 32'h0000_0000);
    bus(1'b0, 8'h0C, 32'h0000_0000, q);
    chk("chopper cfg", q, 32'h0000_0013);
    bus(1'b0, 8'h10, 32'h0000_0000, q);
    chk("load cfg", q, 32'h0005_0040);
    bus(1'b0, 8'h00, 32'h0000_0000, q);
    chk("mode min", q, 32'h0000_0000);
    bus(1'b0, 8'h30, 32'h0000_0000, q);
    chk("unmapped", q, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'hFFFF_FFFF, q);
    bus(1'b0, 8'h18, 32'h0000_0000, q);
    chk("status", q, 32'h0000_0000);
  endtask

  task automatic t_mode;
    bus(1'b1, 8'h0C, 32'h000C_000C, q);
    setv(23'h00_03E8);
    chk("fullstep zero min", 32'(fullstep_active), 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_01F4, q);
    setv(23'h00_01F4);
    chk("fullstep at min", 32'(fullstep_active), 32'h0000_0000);
    setv(23'h00_01F5);
    chk("fullstep above", 32'(fullstep_active), 32'h0000_0001);
    chk("quiet off", 32'(quiet_chopper_disable), 32'h0000_0001);
    chk("off cap", 32'(chopper_off_time_eff), 32'h0000_0008);
    bus(1'b1, 8'h0C, 32'h0004_000C, q);
    chk("one flag", 32'(fullstep_active), 32'h0000_0000);
    bus(1'b1, 8'h0C, 32'h0008_000C, q);
    chk("other flag", 32'(fullstep_active), 32'h0000_0000);
  endtask

  task automatic t_steps;
    logic [31:0] p;
    bus(1'b1, 8'h0C, 32'h000C_000C, q);
    bus(1'b1, 8'h00, 32'h0010_0000, q);
    setv(23'h40_0000);
    bus(1'b0, 8'h28, 32'h0000_0000, p);
    count_steps(8192, free_n);
    bus(1'b0, 8'h28, 32'h0000_0000, q);
    chk("fullstep position", 32'(q[7:0]), 32'(p[7:0]));
    chk("quadrant centre", 32'(microstep_counter[7:0]), 32'h0000_0080);
    bus(1'b0, 8'h20, 32'h0000_0000, q);
    chk("ramp velocity", q, 32'h0040_0000);
    @(posedge clk_sys);
    blocked <= 1'b1;
    count_steps(8192, blk_n);
    chk("blocked min speed", 32'(blk_n >= 2), 32'h0000_0001);
    chk("blocked slower", 32'(free_n > blk_n), 32'h0000_0001);
    bus(1'b0, 8'h1C, 32'h0000_0000, q);
    chk("load blocked", q, 32'h0000_0000);
    bus(1'b0, 8'h18, 32'h0000_0000, q);
    chk("stall flag", q & 32'h0000_0003, 32'h0000_0002);
    @(posedge clk_sys);
    blocked <= 1'b0;
    count_steps(4096, n);
    chk("resume", 32'(n >= 3), 32'h0000_0001);
  endtask

  task automatic t_stall;
    // Load minimum just above mode minimum keeps stall detection live
    bus(1'b1, 8'h04, 32'h0010_0001, q);
    bus(1'b1, 8'h14, 32'h0000_0001, q);
    @(posedge clk_sys);
    blocked <= 1'b1;
    n = 0;
    while (ramp_stop_request !== 1'b1 && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      close_out();
    end
    count_steps(300, n);
    chk("steps in stop", 32'(n), 32'h0000_0000);
    chk("held stop", 32'(ramp_stop_request), 32'h0000_0001);
    bus(1'b0, 8'h18, 32'h0000_0000, q);
    chk("status stop", q, 32'h0000_0007);
    chk("stop released", 32'(ramp_stop_request), 32'h0000_0000);
    setv(23'h10_0000);
    chk("load meas off", 32'(load_measure_active), 32'h0000_0000);
    chk("microstep at min", 32'(fullstep_active), 32'h0000_0000);
    @(posedge clk_sys);
    ramp_dir <= 1'b1;
    @(negedge clk_sys);
    q = 32'(microstep_counter);
    count_steps(160, n);
    chk("step dir", 32'(step_dir), 32'h0000_0001);
    chk("reverse steps", 32'(n), 32'h0000_000A);
    chk("reverse count", 32'(microstep_counter),
        {22'h00_0000, q[9:0] - 10'h00A});
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    close_out();
  end

  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    ramp_velocity = 23'h00_0000;
    ramp_dir = 1'b0;
    blocked = 1'b0;
    settle_cycles = 12'h008;
    checked = 0;
    mismatches = 0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_mode();
    t_steps();
    t_stall();
    close_out();
  end
endmodule
